// ==== shared/csc_pkg.sv ====
package csc_pkg;

   // ------------------------------------------------------------------
   // Register offsets.
   // ------------------------------------------------------------------
   localparam logic [3:0] OFS_PROTECT = 4'h0;
   localparam logic [3:0] OFS_CTRL0 = 4'h1;
   localparam logic [3:0] OFS_CTRL1 = 4'h2;
   localparam logic [3:0] OFS_CTRL2 = 4'h3;
   localparam logic [3:0] OFS_DIVIDER = 4'h4;
   localparam logic [3:0] OFS_PMODE0 = 4'h5;
   localparam logic [3:0] OFS_PMODE2 = 4'h6;
   localparam logic [3:0] OFS_PLL = 4'h7;

   // ------------------------------------------------------------------
   // Field positions.
   // ------------------------------------------------------------------
   localparam int B_PROTECT_EN = 0;
   localparam int B_PERIPH_STOP_WAIT = 2;
   localparam int B_STOP_IND = 3;
   localparam int B_SUB_OSC_EN = 4;
   localparam int B_MAIN_STOP = 5;
   localparam int B_STICKY = 6;
   localparam int B_SUB_SEL = 7;
   localparam int B_STOP_MODE = 0;
   localparam int B_PLL_SEL = 7;
   localparam int B_DETECT_EN = 0;
   localparam int B_ONCHIP_SEL = 1;
   localparam int B_LOSS_FLAG = 2;
   localparam int B_MAIN_STOPPED = 3;
   localparam int B_BUS_CLK_OUT = 7;
   localparam int B_CLK_LOCK = 1;
   localparam int B_WDT_ONCHIP = 2;
   localparam int B_PLL_EN = 7;

   // ------------------------------------------------------------------
   // Reset and forced values.
   // ------------------------------------------------------------------
   localparam logic [4:0] DIV_BY8 = 5'h08;
   localparam logic [1:0] CLKOUT_SEL_BCLK = 2'h0;
   localparam logic [2:0] PLL_MULT_RST = 3'h0;

   // ------------------------------------------------------------------
   // Timing.
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int LOSS_TIME_NS = 2000;
   localparam int LOSS_CYCLES = (LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ------------------------------------------------------------------
   // Types.
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      SRC_MAIN = 3'h0,
      SRC_SUB = 3'h1,
      SRC_ONCHIP = 3'h2,
      SRC_PLL = 3'h3,
      SRC_OFF = 3'h4
   } csc_src_e;

   typedef enum logic [1:0] {
      SW_RUN = 2'h0,
      SW_DRAIN = 2'h1,
      SW_FILL = 2'h2
   } csc_sw_e;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } csc_bus_s;

   typedef struct packed {
      logic main_crystal_output_high;
      logic feedback_off;
      logic osc_pins_hiz;
      logic main_run;
      logic sub_run;
      logic onchip_run;
      logic pll_run;
   } csc_osc_s;

endpackage : csc_pkg

// ==== verilog/csc_clock_source_control.sv ====
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Bus clock out only when bit 0, select 00b
// [RULE2] Clock registers writable only after protect enable
// [RULE3] Lock bit freezes clock-change bits and PLL
// [RULE4] Main stop drives crystal high, forces divide-by-8 unless on-chip select is set
// [RULE5] Sticky configuration bit is set-only
// [RULE6] Software sequences sub clock select safely
// [RULE7] Stop entry sets stop indication bit
// [RULE8] Software sets sub oscillator pins to input
// [RULE9] Stop mode: crystal high, feedback off, pins hiz
// [RULE10] Watchdog on-chip bit blocks stop-mode writes
// [RULE11] Software selects PLL only after it stabilizes
// [RULE12] Loss with detection sets on-chip select, sticky
// [RULE13] Loss flag set by hardware, re-arms after restart
// [RULE14] Software keeps on-chip select while loss pending
// [RULE15] Software samples stopped status several times
// [RULE16] PLL multiplier written once, only PLL disabled
// [RULE17] Software writes both PLL registers in one access
// [RULE18] Software deselects then disables PLL before sleep
// [RULE19] Software reselects source before stopping main
// [RULE20] Loss raises interrupt and starts on-chip oscillator
// [RULE21] Loss sets main-clock-stopped status
// [RULE22] Lock keeps CPU clock running through wait
// [RULE23] Source switches never truncate CPU clock pulses
module csc_clock_source_control #(
   parameter int LOSS_CNT = csc_pkg::LOSS_CYCLES
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic srst,
   // Register port.
   input wire csc_pkg::csc_bus_s bus,
   output logic [15:0] rdata,
   // Oscillator levels, sampled on clk_sys.
   input wire logic main_osc_lvl,
   input wire logic sub_osc_lvl,
   input wire logic onchip_osc_lvl,
   input wire logic pll_osc_lvl,
   // CPU state.
   input wire logic micro_mode,
   input wire logic wait_req,
   input wire logic wake_evt,
   // Clock outputs.
   output logic cpu_clk,
   output logic clock_out_pin,
   output logic clock_out_pin_oe,
   // Oscillator control.
   output csc_pkg::csc_osc_s osc,
   output logic [4:0] main_divider_field,
   output logic [2:0] pll_multiplier_field,
   output logic osc_stop_irq
);

   // ------------------------------------------------------------------
   // Parameter check.
   // ------------------------------------------------------------------
   generate
      if (LOSS_CNT < 2 || LOSS_CNT > 65535) begin : g_bad
         $error("LOSS_CNT out of range");
      end
   endgenerate

   // ------------------------------------------------------------------
   // Register state.
   // ------------------------------------------------------------------
   logic register_protect_enable_r;
   logic [7:0] ctrl0_r;
   logic stop_mode_bit_r;
   logic pll_select_r;
   logic stop_detect_enable_r;
   logic on_chip_osc_select_r;
   logic loss_detected_flag_r;
   logic main_clock_stopped_status_r;
   logic [4:0] div_r;
   logic bus_clock_output_bit_r;
   logic clock_change_lock_r;
   logic watchdog_on_chip_clock_r;
   logic pll_enable_r;
   logic [2:0] pll_mult_r;
   logic mult_written_r;
   logic [7:0] pll_control_reg1_r;
   logic [15:0] idle_cnt_r;
   logic main_prev_r;
   logic loss_evt;
   logic wr_ok;
   logic lock;
   logic [7:0] wd;

   assign wr_ok = bus.wr & register_protect_enable_r; // [RULE2]
   assign lock = clock_change_lock_r;
   assign wd = bus.wdata[7:0];

   // ------------------------------------------------------------------
   // Protect register.
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         register_protect_enable_r <= 1'b0;
      end else if (bus.wr && bus.addr == csc_pkg::OFS_PROTECT) begin
         register_protect_enable_r <= wd[csc_pkg::B_PROTECT_EN];
      end
   end

   // ------------------------------------------------------------------
   // Control register 0.
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctrl0_r <= 8'h00;
      end else begin
         if (wr_ok && bus.addr == csc_pkg::OFS_CTRL0) begin
            ctrl0_r[1:0] <= wd[1:0];
            ctrl0_r[csc_pkg::B_SUB_OSC_EN] <= wd[csc_pkg::B_SUB_OSC_EN];
            if (!lock) begin // [RULE3]
               ctrl0_r[csc_pkg::B_PERIPH_STOP_WAIT] <= wd[csc_pkg::B_PERIPH_STOP_WAIT];
               ctrl0_r[csc_pkg::B_MAIN_STOP] <= wd[csc_pkg::B_MAIN_STOP];
               ctrl0_r[csc_pkg::B_SUB_SEL] <= wd[csc_pkg::B_SUB_SEL];
            end
            if (wd[csc_pkg::B_STICKY]) begin
               ctrl0_r[csc_pkg::B_STICKY] <= 1'b1; // [RULE5]
            end
            if (!wd[csc_pkg::B_STOP_IND]) begin
               ctrl0_r[csc_pkg::B_STOP_IND] <= 1'b0;
            end
         end
         if (stop_mode_bit_r) begin
            ctrl0_r[csc_pkg::B_STOP_IND] <= 1'b1; // [RULE7]
         end
      end
   end

   // ------------------------------------------------------------------
   // Control register 1 and stop mode.
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         stop_mode_bit_r <= 1'b0;
         pll_select_r <= 1'b0;
      end else begin
         if (wr_ok && bus.addr == csc_pkg::OFS_CTRL1 && !lock) begin // [RULE3]
            pll_select_r <= wd[csc_pkg::B_PLL_SEL];
            if (!watchdog_on_chip_clock_r && wd[csc_pkg::B_STOP_MODE]) begin // [RULE10]
               stop_mode_bit_r <= 1'b1;
            end
         end
         if (stop_mode_bit_r && wake_evt) begin
            stop_mode_bit_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Control register 2 and loss detection.
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         main_prev_r <= 1'b0;
         idle_cnt_r <= 16'h0000;
         main_clock_stopped_status_r <= 1'b0;
      end else begin
         main_prev_r <= main_osc_lvl;
         if (main_osc_lvl != main_prev_r) begin
            idle_cnt_r <= 16'h0000;
            main_clock_stopped_status_r <= 1'b0;
         end else if (idle_cnt_r == 16'(LOSS_CNT - 1)) begin
            main_clock_stopped_status_r <= 1'b1; // [RULE21]
         end else begin
            idle_cnt_r <= idle_cnt_r + 16'h0001;
         end
      end
   end

   // A loss is a fresh transition to stopped, so a cleared flag re-arms only after a restart.
   assign loss_evt = (idle_cnt_r == 16'(LOSS_CNT - 1)) && (main_osc_lvl == main_prev_r)
      && !main_clock_stopped_status_r && !ctrl0_r[csc_pkg::B_MAIN_STOP]
      && !stop_mode_bit_r; // [RULE13]
   assign osc_stop_irq = loss_evt & stop_detect_enable_r; // [RULE20]

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         stop_detect_enable_r <= 1'b0;
         on_chip_osc_select_r <= 1'b0;
         loss_detected_flag_r <= 1'b0;
      end else begin
         if (wr_ok && bus.addr == csc_pkg::OFS_CTRL2) begin
            if (!lock) begin // [RULE3]
               stop_detect_enable_r <= wd[csc_pkg::B_DETECT_EN];
            end
            on_chip_osc_select_r <= wd[csc_pkg::B_ONCHIP_SEL];
            if (!wd[csc_pkg::B_LOSS_FLAG]) begin
               loss_detected_flag_r <= 1'b0; // [RULE13]
            end
         end
         if (loss_evt) begin
            loss_detected_flag_r <= 1'b1; // [RULE13]
         end
         if (loss_evt && stop_detect_enable_r) begin
            on_chip_osc_select_r <= 1'b1; // [RULE12]
         end
      end
   end

   // ------------------------------------------------------------------
   // Divider register.
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         div_r <= csc_pkg::DIV_BY8;
      end else if (stop_mode_bit_r) begin
         div_r <= csc_pkg::DIV_BY8; // [RULE9]
      end else if (ctrl0_r[csc_pkg::B_MAIN_STOP] && !on_chip_osc_select_r) begin
         div_r <= csc_pkg::DIV_BY8; // [RULE4]
      end else if (wr_ok && bus.addr == csc_pkg::OFS_DIVIDER) begin
         div_r <= wd[4:0];
      end
   end

   // ------------------------------------------------------------------
   // Processor mode registers.
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         bus_clock_output_bit_r <= 1'b1;
         clock_change_lock_r <= 1'b0;
         watchdog_on_chip_clock_r <= 1'b0;
      end else begin
         if (wr_ok && bus.addr == csc_pkg::OFS_PMODE0) begin
            bus_clock_output_bit_r <= wd[csc_pkg::B_BUS_CLK_OUT];
         end
         if (wr_ok && bus.addr == csc_pkg::OFS_PMODE2) begin
            clock_change_lock_r <= wd[csc_pkg::B_CLK_LOCK];
            watchdog_on_chip_clock_r <= wd[csc_pkg::B_WDT_ONCHIP];
         end
      end
   end

   // ------------------------------------------------------------------
   // PLL control registers, both bytes in one access.
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pll_enable_r <= 1'b0;
         pll_mult_r <= csc_pkg::PLL_MULT_RST;
         mult_written_r <= 1'b0;
         pll_control_reg1_r <= 8'h00;
      end else if (wr_ok && bus.addr == csc_pkg::OFS_PLL && !lock) begin // [RULE3]
         pll_enable_r <= wd[csc_pkg::B_PLL_EN];
         if (!pll_enable_r && !mult_written_r) begin // [RULE16]
            pll_mult_r <= wd[2:0];
            pll_control_reg1_r <= bus.wdata[15:8];
            mult_written_r <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Read data.
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdata <= 16'h0000;
      end else if (bus.rd) begin
         case (bus.addr)
            csc_pkg::OFS_PROTECT: rdata <= {15'h0000, register_protect_enable_r};
            csc_pkg::OFS_CTRL0: rdata <= {8'h00, ctrl0_r};
            csc_pkg::OFS_CTRL1: rdata <= {8'h00, pll_select_r, 6'h00, stop_mode_bit_r};
            csc_pkg::OFS_CTRL2: rdata <= {12'h000, main_clock_stopped_status_r,
               loss_detected_flag_r, on_chip_osc_select_r, stop_detect_enable_r};
            csc_pkg::OFS_DIVIDER: rdata <= {11'h000, div_r};
            csc_pkg::OFS_PMODE0: rdata <= {8'h00, bus_clock_output_bit_r, 7'h00};
            csc_pkg::OFS_PMODE2: rdata <= {13'h0000, watchdog_on_chip_clock_r,
               clock_change_lock_r, 1'b0};
            csc_pkg::OFS_PLL: rdata <= {pll_control_reg1_r, pll_enable_r, 4'h0, pll_mult_r};
            default: rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end

   // ------------------------------------------------------------------
   // Glitch-free CPU clock switch.
   // ------------------------------------------------------------------
   csc_pkg::csc_src_e src_cur_r;
   csc_pkg::csc_src_e src_want;
   csc_pkg::csc_sw_e sw_r;
   logic [4:0] src_lvl;
   logic gate_off;

   assign src_lvl = {1'b0, pll_osc_lvl, onchip_osc_lvl, sub_osc_lvl, main_osc_lvl};
   assign gate_off = stop_mode_bit_r | (wait_req & ~lock); // [RULE22]

   always_comb begin
      if (gate_off) begin
         src_want = csc_pkg::SRC_OFF;
      end else if (ctrl0_r[csc_pkg::B_SUB_SEL]) begin
         src_want = csc_pkg::SRC_SUB;
      end else if (on_chip_osc_select_r) begin
         src_want = csc_pkg::SRC_ONCHIP;
      end else if (pll_select_r) begin
         src_want = csc_pkg::SRC_PLL;
      end else begin
         src_want = csc_pkg::SRC_MAIN;
      end
   end

   // Leave the old source only on its low phase, join the new one on its low phase.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sw_r <= csc_pkg::SW_RUN;
         src_cur_r <= csc_pkg::SRC_MAIN;
         cpu_clk <= 1'b0;
      end else begin
         case (sw_r)
            csc_pkg::SW_RUN: begin
               cpu_clk <= src_lvl[src_cur_r];
               if (src_want != src_cur_r && !src_lvl[src_cur_r]) begin // [RULE23]
                  sw_r <= csc_pkg::SW_DRAIN;
                  cpu_clk <= 1'b0;
               end
            end
            csc_pkg::SW_DRAIN: begin
               cpu_clk <= 1'b0;
               src_cur_r <= src_want;
               sw_r <= csc_pkg::SW_FILL;
            end
            csc_pkg::SW_FILL: begin
               cpu_clk <= 1'b0;
               if (!src_lvl[src_cur_r]) begin // [RULE23]
                  sw_r <= csc_pkg::SW_RUN;
               end
            end
            default: begin
               sw_r <= csc_pkg::SW_RUN;
               cpu_clk <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Pins and oscillator control.
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         clock_out_pin <= 1'b0;
         clock_out_pin_oe <= 1'b0;
         osc <= '0;
      end else begin
         clock_out_pin <= cpu_clk;
         clock_out_pin_oe <= micro_mode && !bus_clock_output_bit_r
            && ctrl0_r[1:0] == csc_pkg::CLKOUT_SEL_BCLK; // [RULE1]
         osc.main_crystal_output_high <= ctrl0_r[csc_pkg::B_MAIN_STOP] | stop_mode_bit_r; // [RULE4]
         osc.feedback_off <= stop_mode_bit_r; // [RULE9]
         osc.osc_pins_hiz <= stop_mode_bit_r; // [RULE9]
         osc.main_run <= ~ctrl0_r[csc_pkg::B_MAIN_STOP] & ~stop_mode_bit_r;
         osc.sub_run <= ctrl0_r[csc_pkg::B_SUB_OSC_EN] & ~stop_mode_bit_r;
         osc.onchip_run <= on_chip_osc_select_r | watchdog_on_chip_clock_r | osc_stop_irq; // [RULE20]
         osc.pll_run <= pll_enable_r & ~stop_mode_bit_r;
      end
   end

   assign main_divider_field = div_r;
   assign pll_multiplier_field = pll_mult_r;

endmodule : csc_clock_source_control

// ==== test/csc_clock_source_control_checker.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Port checker for the clock source control.
// ------------------------------------------------------------------
module csc_clock_source_control_checker #(
   parameter int LOSS_CNT = 80
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic srst,
   // Register port.
   input wire csc_pkg::csc_bus_s bus,
   input wire logic [15:0] rdata,
   // Oscillator and mode inputs.
   input wire logic main_osc_lvl,
   input wire logic micro_mode,
   // Outputs under watch.
   input wire logic cpu_clk,
   input wire logic clock_out_pin,
   input wire logic clock_out_pin_oe,
   input wire csc_pkg::csc_osc_s osc,
   input wire logic [4:0] main_divider_field,
   input wire logic [2:0] pll_multiplier_field,
   input wire logic osc_stop_irq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   logic lvl_r;
   logic [15:0] run_r;
   logic mult_set_r;

   // Counts cycles for which the main oscillator level has not moved.
   always_ff @(posedge clk_sys) begin
      lvl_r <= main_osc_lvl;
      if (srst || main_osc_lvl != lvl_r) begin
         run_r <= 16'h0;
      end else if (run_r != 16'hffff) begin
         run_r <= run_r + 16'h1;
      end
   end

   // Remembers that the multiplier has taken its one write.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mult_set_r <= 1'b0;
      end else if ($changed(pll_multiplier_field)) begin
         mult_set_r <= 1'b1;
      end
   end

   rdata_one_cycle_a: assert property (rdata != 16'h0 |-> $past(bus.rd))
      else $error("read data outside the answer cycle");
   bus_clk_mode_a: assert property (clock_out_pin_oe |-> $past(micro_mode))
      else $error("bus clock driven outside microprocessor mode");
   bus_clk_copy_a: assert property (clock_out_pin_oe |-> clock_out_pin == $past(cpu_clk))
      else $error("clock pin does not carry the bus clock");
   stop_pins_a: assert property (osc.feedback_off |-> osc.main_crystal_output_high && osc.osc_pins_hiz)
      else $error("stop mode pin states wrong");
   stop_divider_a:
      assert property (osc.feedback_off && $past(osc.feedback_off) |->
         main_divider_field == csc_pkg::DIV_BY8)
      else $error("divider not forced in stop mode");
   irq_pulse_a: assert property (osc_stop_irq |=> !osc_stop_irq)
      else $error("stop interrupt longer than one cycle");
   irq_wait_a: assert property (osc_stop_irq |-> run_r + 16'h3 >= LOSS_CNT)
      else $error("stop interrupt before the loss time");
   irq_onchip_a: assert property (osc_stop_irq |-> ##[1:2] osc.onchip_run)
      else $error("on-chip oscillator not started on loss");
   mult_once_a: assert property (mult_set_r |-> $stable(pll_multiplier_field))
      else $error("multiplier changed after its first write");
   mult_by_write_a:
      assert property ($changed(pll_multiplier_field) |->
         $past(bus.wr) && $past(bus.addr) == csc_pkg::OFS_PLL)
      else $error("multiplier changed without a write");
endmodule : csc_clock_source_control_checker

bind csc_clock_source_control csc_clock_source_control_checker #(.LOSS_CNT(LOSS_CNT)) u_chk (
   .clk_sys, .srst, .bus, .rdata, .main_osc_lvl, .micro_mode, .cpu_clk, .clock_out_pin,
   .clock_out_pin_oe, .osc, .main_divider_field, .pll_multiplier_field, .osc_stop_irq);

// ==== test/csc_clock_source_control_tb.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Self-checking bench for the clock source control.
// ------------------------------------------------------------------
module csc_clock_source_control_tb;
   localparam int LOSS = 4;
   typedef struct packed {
      logic [3:0] a;
      logic [15:0] d;
      logic [15:0] m;
      logic [15:0] e;
   } csc_row_s;
   logic clk_sys, srst, main_on, main_osc_lvl, sub_osc_lvl, onchip_osc_lvl, pll_osc_lvl;
   logic micro_mode, wait_req, wake_evt, cpu_clk, clock_out_pin, clock_out_pin_oe, osc_stop_irq;
   csc_pkg::csc_bus_s bus;
   csc_pkg::csc_osc_s osc;
   logic [15:0] rdata, rd_val;
   logic [4:0] main_divider_field;
   logic [2:0] pll_multiplier_field;
   int fail_count, n_compared, rises, k;
   csc_row_s rows [7] = '{
      '{csc_pkg::OFS_PROTECT, 16'h0001, 16'h0001, 16'h0001},
      '{csc_pkg::OFS_CTRL0, 16'h0040, 16'h0043, 16'h0040},
      '{csc_pkg::OFS_DIVIDER, 16'h0002, 16'h001f, 16'h0002},
      '{csc_pkg::OFS_PMODE0, 16'h0000, 16'h0080, 16'h0000},
      '{csc_pkg::OFS_CTRL2, 16'h0001, 16'h0001, 16'h0001},
      '{csc_pkg::OFS_PMODE2, 16'h0000, 16'h0006, 16'h0000},
      '{csc_pkg::OFS_PLL, 16'h0003, 16'h0007, 16'h0003}};

   csc_clock_source_control #(.LOSS_CNT(LOSS)) dut (
      .clk_sys, .srst, .bus, .rdata, .main_osc_lvl, .sub_osc_lvl, .onchip_osc_lvl,
      .pll_osc_lvl, .micro_mode, .wait_req, .wake_evt, .cpu_clk, .clock_out_pin,
      .clock_out_pin_oe, .osc, .main_divider_field, .pll_multiplier_field, .osc_stop_irq);

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Oscillators toggle every cycle; the main one only while main_on.
   always @(posedge clk_sys) begin
      sub_osc_lvl <= ~sub_osc_lvl;
      onchip_osc_lvl <= ~onchip_osc_lvl;
      pll_osc_lvl <= ~pll_osc_lvl;
      if (main_on) main_osc_lvl <= ~main_osc_lvl;
   end

   // ------------------------------------------------------------------
   // Bus cycles, comparison and closing report.
   // ------------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1;
      rd_val = rdata;
   endtask : rd

   task automatic count_rises(input int n);
      logic last;
      rises = 0;
      last = cpu_clk;
      repeat (n) begin
         cyc(1);
         if (cpu_clk === 1'b1 && last !== 1'b1) rises++;
         last = cpu_clk;
      end
   endtask : count_rises

   task automatic give_verdict();
      $display("Compared %0d, failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict

   // ------------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------------
   initial begin
      bus = '0;
      {srst, main_on, micro_mode} = 3'b111;
      {main_osc_lvl, sub_osc_lvl, onchip_osc_lvl, pll_osc_lvl} = 4'h0;
      {wait_req, wake_evt} = 2'b00;
      fail_count = 0;
      n_compared = 0;
      repeat (6) @(posedge clk_sys);
      srst <= 1'b0;
      cyc(1);
      check("divider reset", 16'h0008, {11'h0, main_divider_field});
      check("pin enable reset", 16'h0000, {15'h0, clock_out_pin_oe});
      rd(csc_pkg::OFS_PMODE0);
      check("bus clock bit reset", 16'h0080, rd_val & 16'h0080);
      wr(csc_pkg::OFS_DIVIDER, 16'h0001);
      cyc(2);
      check("unprotected divider", 16'h0008, {11'h0, main_divider_field});
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         check("register readback", rows[i].e, rd_val & rows[i].m);
      end
      wr(csc_pkg::OFS_CTRL0, 16'h0000);
      rd(csc_pkg::OFS_CTRL0);
      check("sticky bit", 16'h0040, rd_val & 16'h0040);
      wr(csc_pkg::OFS_PLL, 16'h0005);
      cyc(2);
      check("multiplier", 16'h0003, {13'h0, pll_multiplier_field});
      check("bus clock on", 16'h0001, {15'h0, clock_out_pin_oe});
      @(posedge clk_sys);
      micro_mode <= 1'b0;
      cyc(3);
      check("bus clock single chip", 16'h0000, {15'h0, clock_out_pin_oe});
      micro_mode <= 1'b1;
      wr(csc_pkg::OFS_CTRL0, 16'h0041);
      cyc(3);
      check("bus clock other select", 16'h0000, {15'h0, clock_out_pin_oe});
      wr(csc_pkg::OFS_CTRL0, 16'h0040);
      // Clock change lock.
      wr(csc_pkg::OFS_PMODE2, 16'h0002);
      wr(csc_pkg::OFS_CTRL1, 16'h0001);
      cyc(3);
      check("locked stop", 16'h0000, {15'h0, osc.feedback_off});
      wr(csc_pkg::OFS_CTRL2, 16'h0000);
      rd(csc_pkg::OFS_CTRL2);
      check("locked detect enable", 16'h0001, rd_val & 16'h0001);
      wait_req <= 1'b1;
      count_rises(20);
      check("locked wait clock", 16'h0001, {15'h0, rises > 0});
      wr(csc_pkg::OFS_PMODE2, 16'h0000);
      cyc(6);
      count_rises(10);
      check("wait clock stopped", 16'h0000, rises[15:0]);
      wait_req <= 1'b0;
      wr(csc_pkg::OFS_PMODE2, 16'h0004);
      wr(csc_pkg::OFS_CTRL1, 16'h0001);
      cyc(3);
      check("watchdog stop", 16'h0000, {15'h0, osc.feedback_off});
      wr(csc_pkg::OFS_PMODE2, 16'h0000);
      // Main clock loss.
      main_on <= 1'b0;
      k = 0;
      while (osc_stop_irq !== 1'b1 && k < 50) begin
         cyc(1);
         k++;
      end
      if (k == 50) begin
         fail_count++;
         $display("CHECK FAILED stop interrupt expected 1 seen 0");
         give_verdict();
      end
      cyc(2);
      check("on-chip running", 16'h0001, {15'h0, osc.onchip_run});
      rd(csc_pkg::OFS_CTRL2);
      check("loss status", 16'h000e, rd_val & 16'h000e);
      wr(csc_pkg::OFS_CTRL2, 16'h0003);
      cyc(LOSS + 4);
      rd(csc_pkg::OFS_CTRL2);
      check("loss flag cleared", 16'h0000, rd_val & 16'h0004);
      main_on <= 1'b1;
      cyc(8);
      rd(csc_pkg::OFS_CTRL2);
      check("on-chip select held", 16'h0002, rd_val & 16'h0002);
      wr(csc_pkg::OFS_CTRL2, 16'h0000);
      // Main clock stop after moving to the sub clock.
      wr(csc_pkg::OFS_CTRL0, 16'h0050);
      wr(csc_pkg::OFS_CTRL0, 16'h00d0);
      wr(csc_pkg::OFS_CTRL0, 16'h00f0);
      cyc(3);
      check("main off sub on", 16'h0001, {14'h0, osc.main_run, osc.sub_run});
      check("main stop pin", 16'h0001, {15'h0, osc.main_crystal_output_high});
      check("main stop divider", 16'h0008, {11'h0, main_divider_field});
      wr(csc_pkg::OFS_CTRL0, 16'h00d0);
      wr(csc_pkg::OFS_CTRL0, 16'h0050);
      // Stop mode and wake-up.
      wr(csc_pkg::OFS_DIVIDER, 16'h0002);
      wr(csc_pkg::OFS_CTRL1, 16'h0001);
      cyc(3);
      check("stop pins", 16'h0007, {13'h0, osc.feedback_off, osc.main_crystal_output_high, osc.osc_pins_hiz});
      check("stop divider", 16'h0008, {11'h0, main_divider_field});
      rd(csc_pkg::OFS_CTRL0);
      check("stop indication", 16'h0008, rd_val & 16'h0008);
      wake_evt <= 1'b1;
      @(posedge clk_sys);
      wake_evt <= 1'b0;
      cyc(3);
      check("woken", 16'h0000, {15'h0, osc.feedback_off});
      // Reset in mid-run.
      srst <= 1'b1;
      cyc(2);
      srst <= 1'b0;
      cyc(1);
      check("divider after reset", 16'h0008, {11'h0, main_divider_field});
      check("multiplier after reset", 16'h0000, {13'h0, pll_multiplier_field});
      give_verdict();
   end
endmodule : csc_clock_source_control_tb
